// file: core/spc_consts.svh
// constants for the self program control block
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_CSR_ADDR 6'h37
`define SPC_CSR_RESET 8'h00
`define SPC_BIT_IRQ_EN 7
`define SPC_BIT_SIGNATURE_READ 5
`define SPC_BIT_RWWRE 4
`define SPC_BIT_LOCK 3
`define SPC_BIT_PGWR 2
`define SPC_BIT_PGER 1
`define SPC_BIT_EN 0
`define SPC_CMD_RWWRE 5'h11
`define SPC_CMD_LOCK 5'h09
`define SPC_CMD_PGWR 5'h05
`define SPC_CMD_PGER 5'h03
`define SPC_CMD_FILL 5'h01
`define SPC_SPM_WINDOW 3'h4
`define SPC_LPM_WINDOW 3'h3
`define SPC_RC_HZ 128000
`define SPC_PROG_MIN_US 3700
`define SPC_PROG_MAX_US 4500
`define SPC_PROG_TICKS ((`SPC_PROG_MIN_US * `SPC_RC_HZ + 999999) / 1000000)
`define SPC_PROG_MAX_TICKS ((`SPC_PROG_MAX_US * `SPC_RC_HZ) / 1000000)
`define SPC_PAGE_WORDS 32
`endif

// file: core/spc_pkg.sv
// types for the self program control block
package spc_pkg;
    typedef enum logic [2:0] {
        SPC_IDLE = 3'b001,
        SPC_ARMED = 3'b010,
        SPC_BUSY = 3'b100
    } spc_state_t;
endpackage

// file: core/spc_self_program_control.sv
// self program control and status register with spm/lpm sequencing
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.svh"
// How it works
// R1: a flash erase or write lasts 3.7 to 4.5 ms, timed by rc oscillator ticks.
// R2: ready interrupt needs enable bit and global i bit; asserts while enable clear.
// R3: no ready interrupt during eeprom write or busy store-program operation.
// R4: section busy bit 6 is read-only and always reads zero.
// R5: signature read: lpm in three cycles returns signature byte; spm does nothing.
// R6: writing section read enable during buffer fill clears the whole buffer.
// R7: lock read: lpm in three cycles returns lock or fuse byte by z pointer.
// R8: page write command writes the buffer to page at z upper bits.
// R9: page write bit clears at end or timeout; cpu halted meanwhile.
// R10: page erase command erases page at z upper bits, then auto-clears.
// R11: self program enable allows spm only for the next four cycles.
// R12: enable alone: spm stores the data pair into buffer word from z.
// R13: enable clears after spm or four idle cycles; stays during erase/write.
// R14: only the five listed low-bit command values take effect.
// R15: software should poll the section busy flag after programming.
// R16: software waits for enable bit clear before a new command.
// R17: software disables interrupts and waits for eeprom idle before writing.
// R18: eeprom write blocks store-program operations and fuse or lock reads.
// R19: buffer erased after page write and reset; each word written once.
// R20: z 0 fuse low, 1 lock, 2 extended fuse, 3 fuse high.
// R21: fuse and lock bits read zero when programmed, one when not.
// R22: each enable write restarts the window; expiry clears the command bits. A write in the expiry cycle or with a taken spm/lpm is dropped.
module spc_self_program_control (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_io_we,
    input wire logic [5:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    input wire logic i_spm,
    input wire logic i_lpm,
    input wire logic [15:0] i_z_ptr,
    input wire logic [15:0] i_write_data_pair,
    input wire logic i_global_irq,
    input wire logic i_eeprom_write_status,
    input wire logic i_rc_tick,
    input wire logic [7:0] i_fuse_low,
    input wire logic [7:0] i_fuse_high,
    input wire logic [7:0] i_fuse_ext,
    input wire logic [7:0] i_lock_bits,
    input wire logic [7:0] i_sig_byte,
    input wire logic i_flash_done,
    output logic o_lpm_override,
    output logic [7:0] o_lpm_data,
    output logic o_cpu_halt,
    output logic o_flash_erase,
    output logic o_flash_write,
    output logic [9:0] o_flash_page,
    output logic [15:0] o_flash_buf_word,
    output logic o_ready_irq
);
    spc_pkg::spc_state_t state_r, state_nxt;
    logic [7:0] csr_r, csr_nxt;
    logic [2:0] win_r, win_nxt;
    logic [15:0] tick_r, tick_nxt;
    logic [15:0] buf_r [0:`SPC_PAGE_WORDS-1];
    logic [`SPC_PAGE_WORDS-1:0] used_r, used_nxt;
    logic buf_we;
    logic [4:0] buf_idx;
    logic [7:0] lpm_data_nxt;
    logic lpm_ovr_nxt;
    logic [9:0] page_nxt;
    logic erase_nxt, write_nxt;
    logic csr_wr;
    logic [4:0] cmd;

    function automatic logic cmd_legal(input logic [4:0] c);
        cmd_legal = (c == `SPC_CMD_RWWRE) || (c == `SPC_CMD_LOCK) || (c == `SPC_CMD_PGWR)
            || (c == `SPC_CMD_PGER) || (c == `SPC_CMD_FILL);
    endfunction

    function automatic logic [7:0] fuse_sel(input logic [1:0] z, input logic [7:0] fl,
        input logic [7:0] lk, input logic [7:0] fe, input logic [7:0] fh);
        case (z)
            2'h0: fuse_sel = fl;
            2'h1: fuse_sel = lk;
            2'h2: fuse_sel = fe;
            default: fuse_sel = fh;
        endcase
    endfunction

    assign csr_wr = i_io_we && (i_io_addr == `SPC_CSR_ADDR);
    assign cmd = i_io_wdata[4:0];
    assign buf_idx = i_z_ptr[5:1]; // R12
    assign o_io_rdata = {csr_r[7], 1'b0, csr_r[5:0]}; // R4
    assign o_ready_irq = csr_r[`SPC_BIT_IRQ_EN] && i_global_irq && !csr_r[`SPC_BIT_EN]
        && !i_eeprom_write_status && (state_r != spc_pkg::SPC_BUSY); // R2 R3
    assign o_cpu_halt = (state_r == spc_pkg::SPC_BUSY); // R9
    assign o_flash_buf_word = buf_r[i_z_ptr[5:1]];

    always_comb begin
        state_nxt = state_r;
        csr_nxt = csr_r;
        win_nxt = win_r;
        tick_nxt = tick_r;
        used_nxt = used_r;
        buf_we = 1'b0;
        lpm_data_nxt = o_lpm_data;
        lpm_ovr_nxt = 1'b0;
        page_nxt = o_flash_page;
        erase_nxt = 1'b0;
        write_nxt = 1'b0;
        case (state_r)
            spc_pkg::SPC_IDLE: begin
                if (csr_wr) begin
                    csr_nxt[7] = i_io_wdata[7];
                    if (cmd_legal(cmd) && !i_eeprom_write_status) begin // R14 R18
                        csr_nxt[5:0] = i_io_wdata[5:0];
                        win_nxt = 3'h0; // R22
                        state_nxt = spc_pkg::SPC_ARMED;
                        if (cmd == `SPC_CMD_RWWRE) begin
                            used_nxt = '0; // R6
                        end
                    end
                end
            end
            spc_pkg::SPC_ARMED: begin
                win_nxt = win_r + 3'h1;
                if (i_lpm && (win_r < `SPC_LPM_WINDOW) && !i_eeprom_write_status
                    && (csr_r[`SPC_BIT_LOCK] || csr_r[`SPC_BIT_SIGNATURE_READ])) begin
                    lpm_ovr_nxt = 1'b1;
                    lpm_data_nxt = csr_r[`SPC_BIT_SIGNATURE_READ] ? i_sig_byte // R5
                        : fuse_sel(i_z_ptr[1:0], i_fuse_low, i_lock_bits,
                                   i_fuse_ext, i_fuse_high); // R7 R20 R21
                    csr_nxt[5:0] = 6'h00;
                    state_nxt = spc_pkg::SPC_IDLE;
                end else if (i_spm && (win_r < `SPC_SPM_WINDOW) && !i_eeprom_write_status) begin // R11 R18
                    page_nxt = i_z_ptr[15:6];
                    if (csr_r[`SPC_BIT_SIGNATURE_READ] || csr_r[`SPC_BIT_LOCK]) begin
                        csr_nxt[5:0] = 6'h00; // R5
                        state_nxt = spc_pkg::SPC_IDLE;
                    end else if (csr_r[`SPC_BIT_PGWR] || csr_r[`SPC_BIT_PGER]) begin
                        erase_nxt = csr_r[`SPC_BIT_PGER]; // R10
                        write_nxt = csr_r[`SPC_BIT_PGWR]; // R8
                        tick_nxt = 16'h0000;
                        state_nxt = spc_pkg::SPC_BUSY;
                    end else begin
                        if (!csr_r[`SPC_BIT_RWWRE] && !used_r[buf_idx]) begin
                            buf_we = 1'b1; // R12 R19
                            used_nxt[buf_idx] = 1'b1;
                        end
                        csr_nxt[5:0] = 6'h00; // R13
                        state_nxt = spc_pkg::SPC_IDLE;
                    end
                end else if (win_r == `SPC_SPM_WINDOW - 3'h1) begin
                    csr_nxt[5:0] = 6'h00; // R13 R22
                    state_nxt = spc_pkg::SPC_IDLE;
                end
                if (csr_wr && state_nxt == spc_pkg::SPC_ARMED) begin
                    csr_nxt[7] = i_io_wdata[7];
                    if (cmd_legal(cmd) && !i_eeprom_write_status) begin
                        csr_nxt[5:0] = i_io_wdata[5:0];
                        win_nxt = 3'h0; // R22
                        if (cmd == `SPC_CMD_RWWRE) begin
                            used_nxt = '0; // R6
                        end
                    end
                end
            end
            spc_pkg::SPC_BUSY: begin
                if (i_rc_tick) begin
                    tick_nxt = tick_r + 16'h0001; // R1
                end
                if (csr_wr) begin
                    csr_nxt[7] = i_io_wdata[7];
                end
                if ((tick_r >= 16'(`SPC_PROG_TICKS) && i_flash_done)
                    || tick_r >= 16'(`SPC_PROG_MAX_TICKS)) begin // R1
                    if (csr_r[`SPC_BIT_PGWR]) begin
                        used_nxt = '0; // R19
                    end
                    csr_nxt[5:0] = 6'h00; // R9 R10 R13
                    state_nxt = spc_pkg::SPC_IDLE;
                end
            end
            default: state_nxt = spc_pkg::SPC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= spc_pkg::SPC_IDLE;
            csr_r <= `SPC_CSR_RESET;
            win_r <= 3'h0;
            tick_r <= 16'h0000;
            used_r <= '0;
            o_lpm_data <= 8'h00;
            o_lpm_override <= 1'b0;
            o_flash_page <= 10'h000;
            o_flash_erase <= 1'b0;
            o_flash_write <= 1'b0;
        end else begin
            state_r <= state_nxt;
            csr_r <= csr_nxt;
            win_r <= win_nxt;
            tick_r <= tick_nxt;
            used_r <= used_nxt;
            o_lpm_data <= lpm_data_nxt;
            o_lpm_override <= lpm_ovr_nxt;
            o_flash_page <= page_nxt;
            o_flash_erase <= erase_nxt;
            o_flash_write <= write_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (buf_we) begin
            buf_r[buf_idx] <= i_write_data_pair;
        end
    end

    property p_bit6_zero;
        @(posedge i_clk) disable iff (!i_rst_n) o_io_rdata[6] == 1'b0;
    endproperty
    a_bit6_zero: assert property (p_bit6_zero) else $error("busy bit not zero"); // R4

    property p_irq_gate;
        @(posedge i_clk) disable iff (!i_rst_n)
            o_ready_irq |-> (i_global_irq && csr_r[7] && !csr_r[0]);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enables"); // R2

    property p_irq_quiet;
        @(posedge i_clk) disable iff (!i_rst_n)
            (i_eeprom_write_status || o_cpu_halt) |-> !o_ready_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq during write"); // R3

    property p_window;
        @(posedge i_clk) disable iff (!i_rst_n)
            (state_r == spc_pkg::SPC_IDLE) ##1 (state_r == spc_pkg::SPC_ARMED)
            ##0 (!i_spm && !csr_wr) ##1 (!i_spm && !csr_wr) ##1 (!i_spm && !csr_wr)
            ##1 (!i_spm && !i_lpm && !csr_wr) |=> !csr_r[0];
    endproperty
    a_window: assert property (p_window) else $error("enable outlived window"); // R13

    property p_halt_hold;
        @(posedge i_clk) disable iff (!i_rst_n) o_cpu_halt |-> csr_r[0];
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("enable dropped in op"); // R13

    property p_illegal;
        @(posedge i_clk) disable iff (!i_rst_n)
            (state_r == spc_pkg::SPC_IDLE && csr_wr && !cmd_legal(cmd))
            |=> (state_r == spc_pkg::SPC_IDLE);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal command took"); // R14

    property p_min_time;
        @(posedge i_clk) disable iff (!i_rst_n)
            (o_cpu_halt && !state_nxt[2]) |-> tick_r >= 16'(`SPC_PROG_TICKS);
    endproperty
    a_min_time: assert property (p_min_time) else $error("flash op too short"); // R1

    property p_max_time;
        @(posedge i_clk) disable iff (!i_rst_n)
            o_cpu_halt |-> tick_r <= 16'(`SPC_PROG_MAX_TICKS);
    endproperty
    a_max_time: assert property (p_max_time) else $error("flash op too long"); // R1

    property p_ee_block;
        @(posedge i_clk) disable iff (!i_rst_n)
            (i_eeprom_write_status && i_lpm) |=> !o_lpm_override;
    endproperty
    a_ee_block: assert property (p_ee_block) else $error("lpm read in eeprom write"); // R18
endmodule
`default_nettype wire

// file: verif/spc_flash_model.sv
// flash array model: rc tick source and erase/write timing
`timescale 1ns/1ps
`default_nettype none
module spc_flash_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    output logic o_rc_tick,
    output logic o_flash_done
);
    logic [9:0] ticks_r;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rc_tick <= 1'b0;
            ticks_r <= 10'h000;
        end else begin
            o_rc_tick <= ~o_rc_tick;
            if (i_start) begin
                ticks_r <= 10'h1E0;
            end else if (o_rc_tick && ticks_r != 10'h000) begin
                ticks_r <= ticks_r - 10'h001;
            end
        end
    end
    assign o_flash_done = (ticks_r == 10'h000);
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking testbench for the self program control block
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.svh"
module tb;
    logic i_clk = 1'b0, i_rst_n = 1'b0, we = 1'b0, spm = 1'b0, lpm = 1'b0, girq = 1'b1, ee = 1'b0;
    logic [5:0] addr = `SPC_CSR_ADDR;
    logic [7:0] wd = 8'h00, rd, ld, fl = 8'h00, fh = 8'h00, fe = 8'h00, lk = 8'h00, sg = 8'h00;
    logic [15:0] z = 16'h0000, dp = 16'h0000, bw;
    logic [9:0] page;
    logic ovr, halt, ers, wrt, irq, tick, done;
    logic [31:0] lfsr = 32'hC1A2A13B;
    logic [7:0] exp_q[$];
    int mismatches = 0, num_checks = 0, n;
    always #4 i_clk = ~i_clk;
    spc_self_program_control spc_self_program_control_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_io_we(we), .i_io_addr(addr), .i_io_wdata(wd), .o_io_rdata(rd), .i_spm(spm),
        .i_lpm(lpm), .i_z_ptr(z), .i_write_data_pair(dp), .i_global_irq(girq),
        .i_eeprom_write_status(ee), .i_rc_tick(tick), .i_fuse_low(fl), .i_fuse_high(fh),
        .i_fuse_ext(fe), .i_lock_bits(lk), .i_sig_byte(sg), .i_flash_done(done),
        .o_lpm_override(ovr), .o_lpm_data(ld), .o_cpu_halt(halt), .o_flash_erase(ers),
        .o_flash_write(wrt), .o_flash_page(page), .o_flash_buf_word(bw), .o_ready_irq(irq));
    spc_flash_model spc_flash_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(ers | wrt),
        .o_rc_tick(tick), .o_flash_done(done));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
        num_checks++;
        if (seen !== expv) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rnd();
        lfsr = lfsr_step(lfsr);
    endtask
    task automatic csr_wr(input logic [7:0] d, input logic [5:0] a = `SPC_CSR_ADDR);
        we = 1'b1;
        addr = a;
        wd = d;
        cyc(1);
        we = 1'b0;
        addr = `SPC_CSR_ADDR;
    endtask
    task automatic csr_chk(input logic [7:0] e);
        check("csr", {8'h00, rd}, {8'h00, e});
    endtask
    task automatic pulse_spm();
        spm = 1'b1;
        cyc(1);
        spm = 1'b0;
    endtask
    task automatic fill(input logic [15:0] zz, input logic [15:0] d);
        z = zz;
        dp = d;
        csr_wr(8'h81);
        pulse_spm();
        cyc(1);
    endtask
    task automatic prog(input logic [7:0] cmd, input logic is_ers);
        rnd();
        z = {lfsr[9:0], 6'h00};
        csr_wr(cmd);
        pulse_spm();
        n = 0;
        while (!(ers | wrt) && n < 4) begin
            cyc(1);
            n++;
        end
        check("start", {14'h0000, ers, wrt}, {14'h0000, is_ers, !is_ers});
        check("page", {6'h00, page}, {6'h00, z[15:6]});
        cyc(1);
        csr_chk(cmd);
        check("irq busy", {15'h0000, irq}, 16'h0000);
        n = 0;
        while (halt === 1'b1 && n < 1300) begin
            cyc(1);
            n++;
        end
        check("halt span", {15'h0000, n >= 946 && n <= 1152}, 16'h0001);
        if (n >= 1300) complete_run();
        csr_chk(8'h80);
    endtask
    always @(negedge i_clk) begin
        if (ovr === 1'b1) begin
            if (exp_q.size() == 0) check("lpm extra", 16'h0001, 16'h0000);
            else check("lpm data", {8'h00, ld}, {8'h00, exp_q.pop_front()});
        end
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        mismatches++;
        complete_run();
    end
    initial begin
        rnd();
        {fl, fh, fe, lk} = lfsr;
        rnd();
        sg = lfsr[7:0];
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_rst_n = 1'b1;
        csr_chk(`SPC_CSR_RESET);
        csr_wr(8'hC1);
        csr_chk(8'h81);
        cyc(5);
        csr_chk(8'h80);
        check("irq on", {15'h0000, irq}, 16'h0001);
        girq = 1'b0;
        cyc(1);
        check("irq gi", {15'h0000, irq}, 16'h0000);
        girq = 1'b1;
        ee = 1'b1;
        cyc(1);
        check("irq ee", {15'h0000, irq}, 16'h0000);
        csr_wr(8'h89);
        csr_chk(8'h80);
        ee = 1'b0;
        csr_wr(8'h87);
        csr_chk(8'h80);
        csr_wr(8'h01, 6'h36);
        csr_chk(8'h80);
        rnd();
        fill(16'h0042, lfsr[15:0]);
        csr_chk(8'h80);
        fill(16'h0043, ~lfsr[15:0]);
        check("buf once", bw, lfsr[15:0]);
        csr_wr(8'h91);
        cyc(5);
        fill(16'h0042, ~lfsr[15:0]);
        check("buf clear", bw, ~lfsr[15:0]);
        for (int i = 0; i < 4; i++) begin
            z = i[15:0];
            csr_wr(8'h89);
            exp_q.push_back(i == 0 ? fl : i == 1 ? lk : i == 2 ? fe : fh);
            lpm = 1'b1;
            cyc(1);
            lpm = 1'b0;
            cyc(2);
        end
        z = 16'h0001;
        csr_wr(8'h89);
        ee = 1'b1;
        lpm = 1'b1;
        cyc(1);
        lpm = 1'b0;
        ee = 1'b0;
        cyc(4);
        csr_chk(8'h80);
        csr_wr(8'hA1);
        exp_q.push_back(sg);
        lpm = 1'b1;
        cyc(1);
        lpm = 1'b0;
        csr_wr(8'hA1);
        pulse_spm();
        check("sig spm", {13'h0000, halt, ers, wrt}, 16'h0000);
        cyc(4);
        csr_chk(8'h80);
        prog(8'h83, 1'b1);
        prog(8'h85, 1'b0);
        fill(16'h0042, lfsr[31:16]);
        check("buf after wr", bw, lfsr[31:16]);
        check("lpm left", 16'(exp_q.size()), 16'h0000);
        complete_run();
    end
endmodule
`default_nettype wire
